/* File: caww_cfg.svh */
// Constants for the counter array waveform and watchdog block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef CAWW_CFG_SVH
`define CAWW_CFG_SVH
`define CAWW_NMOD 6
`define CAWW_WDOG_MOD 5
// APB byte addresses
`define CAWW_A_CTRL 12'h000
`define CAWW_A_MODE 12'h004
`define CAWW_A_CNTL 12'h008
`define CAWW_A_CNTH 12'h00C
`define CAWW_A_MOD0 12'h010
`define CAWW_A_STEP 12'h010
`define CAWW_A_LAST 12'h06C
// Counter control register fields
`define CAWW_CT_OVF 7
`define CAWW_CT_RUN 6
// Counter mode register fields
`define CAWW_MD_IDLE 7
`define CAWW_MD_WDE 6
`define CAWW_MD_WLK 5
`define CAWW_MD_TBH 3
`define CAWW_MD_TBL 1
`define CAWW_MD_OVIE 0
`define CAWW_MD_RST 8'h40
// Module mode register fields
`define CAWW_MM_WIDE 7
`define CAWW_MM_CMP 6
`define CAWW_MM_MAT 3
`define CAWW_MM_TOG 2
`define CAWW_MM_PWM 1
`define CAWW_MM_IE 0
`define CAWW_MM_TIMER 8'h48
// Timebase codes and prescale
`define CAWW_TB_DIV12 3'h0
`define CAWW_TB_DIV4 3'h1
`define CAWW_TB_T0 3'h2
`define CAWW_TB_EXT 3'h3
`define CAWW_TB_SYS 3'h4
`define CAWW_TB_OSC8 3'h5
`define CAWW_DIV12_LAST 4'hB
`define CAWW_DIV4_LAST 4'h3
`define CAWW_OSC8_LAST 4'h7
`define CAWW_BYTE_MAX 8'hFF
`define CAWW_ZERO8 8'h00
`endif

/* File: caww_pkg.sv */
// Types for the counter array waveform and watchdog block.
// Assumes caww_cfg.svh sits in the include path.
`include "caww_cfg.svh"
package caww_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } caww_apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } caww_apb_rsp_type;
  typedef enum logic [1:0] {
    CAWW_WF_OFF = 2'b00,
    CAWW_WF_FREQ = 2'b01,
    CAWW_WF_PWM8 = 2'b11,
    CAWW_WF_PWM16 = 2'b10
  } caww_wave_type;
endpackage

/* File: caww_core.sv */
// Counter array: 16-bit counter, six compare modules with waveform modes,
// and the module 5 watchdog. Registers over APB, one word each.
// Assumes pins tick_t0_in, ext_edge_in, ext_osc_in, idle_in come from outside.
//
// What this block does
// - Frequency mode: low byte match toggles pin, adds high byte to low byte.
// - High byte zero gives a 256-tick half period in frequency mode.
// - Compare, toggle and PWM enables together select frequency mode.
// - Low byte write clears compare enable; high byte write sets it.
// - 8-bit PWM: pin high on low-byte match, low on low-byte overflow.
// - 8-bit PWM: low byte reloads from high byte at each low-byte wrap.
// - Compare and PWM set, wide select clear, selects 8-bit PWM.
// - Compare enable clear holds PWM at zero duty; zero high byte is full.
// - 16-bit PWM: pin high on full word match, low on counter overflow.
// - Compare, PWM and wide select set selects 16-bit PWM.
// - Watchdog enable makes module 5 compare high byte with counter high byte.
// - Watchdog on after reset; divide-by-12, low byte and offset zero.
// - Watchdog on forces run, freezes counter, timebase, idle, module 5 mode.
// - Under watchdog, run bit writes do not stop counter; run reads zero unless set.
// - Module 5 high byte write reloads counter high byte plus offset.
// - Watchdog reset when low byte overflows while module 5 high byte matches.
// - Writing one to module 5 flag under watchdog forces a reset.
// - Either enable or lock bit turns the watchdog on.
// - Lock holds watchdog on until reset; otherwise enable bit clears it.
// - Match sets sticky flag until software clears it; interrupt if enabled.
`timescale 1ns/1ps
`default_nettype none
`include "caww_cfg.svh"
module caww_core (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire caww_pkg::caww_apb_req_type apb_in,
  output caww_pkg::caww_apb_rsp_type apb_out,
  input wire logic tick_t0_in,
  input wire logic ext_edge_in,
  input wire logic ext_osc_in,
  input wire logic idle_in,
  output logic [5:0] module_output_pin_out,
  output logic irq_out,
  output logic wdog_reset_out
);
  import caww_pkg::*;

  logic [7:0] count_low_byte_r;
  logic [7:0] count_high_byte_r;
  logic [7:0] counter_mode_r;
  logic counter_run_r;
  logic count_ovf_r;
  logic [5:0] module_event_flag_r;
  logic [7:0] module_mode_r [0:5];
  logic [7:0] compare_low_byte_r [0:5];
  logic [7:0] compare_high_byte_r [0:5];
  logic [5:0] module_output_pin_r;
  logic wdog_reset_r;
  logic irq_r;
  logic [3:0] prescale_r;
  logic [2:0] t0_sync_r;
  logic [2:0] ext_sync_r;
  logic [2:0] osc_sync_r;
  logic [1:0] idle_sync_r;
  caww_apb_rsp_type rsp_r;

  logic watchdog_on;
  logic counter_go;
  logic tick;
  logic low_wrap;
  logic full_wrap;
  logic wr;
  logic rd;
  logic [2:0] timebase_select;
  logic [3:0] prescale_last;
  logic [11:0] addr;
  logic [7:0] wbyte;
  logic [5:0] match_evt;
  logic mod_hit;
  logic [2:0] mod_idx;

  function automatic caww_wave_type wave_of(input logic [7:0] mm);
    if (mm[`CAWW_MM_PWM] && mm[`CAWW_MM_TOG] && !mm[`CAWW_MM_MAT]) begin
      wave_of = CAWW_WF_FREQ;
    end else if (mm[`CAWW_MM_PWM] && !mm[`CAWW_MM_TOG] && !mm[`CAWW_MM_MAT]) begin
      wave_of = mm[`CAWW_MM_WIDE] ? CAWW_WF_PWM16 : CAWW_WF_PWM8;
    end else begin
      wave_of = CAWW_WF_OFF;
    end
  endfunction

  function automatic logic is_mod(input logic [11:0] a);
    is_mod = (a >= `CAWW_A_MOD0) && (a <= `CAWW_A_LAST) && (a[1:0] == 2'b00);
  endfunction

  assign addr = apb_in.paddr;
  assign wbyte = apb_in.pwdata[7:0];
  assign wr = apb_in.psel && apb_in.penable && apb_in.pwrite;
  assign rd = apb_in.psel && apb_in.penable && !apb_in.pwrite;
  assign mod_hit = is_mod(addr);
  // Each module owns four words: mode, low, high, spare
  assign mod_idx = 3'((addr - `CAWW_A_MOD0) >> 4);

  assign watchdog_on = counter_mode_r[`CAWW_MD_WDE] || counter_mode_r[`CAWW_MD_WLK];
  assign timebase_select = counter_mode_r[`CAWW_MD_TBH:`CAWW_MD_TBL];
  // Idle halt only pauses the counter; watchdog force still wins otherwise
  assign counter_go = (counter_run_r || watchdog_on)
    && !(counter_mode_r[`CAWW_MD_IDLE] && idle_sync_r[1]);

  always_comb begin
    case (timebase_select)
      `CAWW_TB_DIV12: prescale_last = `CAWW_DIV12_LAST;
      `CAWW_TB_DIV4: prescale_last = `CAWW_DIV4_LAST;
      default: prescale_last = `CAWW_OSC8_LAST;
    endcase
  end

  always_comb begin
    case (timebase_select)
      `CAWW_TB_DIV12, `CAWW_TB_DIV4: tick = prescale_r == prescale_last;
      `CAWW_TB_T0: tick = t0_sync_r[1] && !t0_sync_r[2];
      `CAWW_TB_EXT: tick = ext_sync_r[2] && !ext_sync_r[1];
      `CAWW_TB_SYS: tick = 1'b1;
      `CAWW_TB_OSC8: tick = (osc_sync_r[1] && !osc_sync_r[2]) && prescale_r == prescale_last;
      default: tick = 1'b0;
    endcase
  end

  assign low_wrap = counter_go && tick && count_low_byte_r == `CAWW_BYTE_MAX;
  assign full_wrap = low_wrap && count_high_byte_r == `CAWW_BYTE_MAX;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      t0_sync_r <= 3'h0;
      ext_sync_r <= 3'h0;
      osc_sync_r <= 3'h0;
      idle_sync_r <= 2'h0;
    end else begin
      t0_sync_r <= {t0_sync_r[1:0], tick_t0_in};
      ext_sync_r <= {ext_sync_r[1:0], ext_edge_in};
      osc_sync_r <= {osc_sync_r[1:0], ext_osc_in};
      idle_sync_r <= {idle_sync_r[0], idle_in};
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prescale_r <= 4'h0;
    end else if (wdog_reset_r || !counter_go) begin
      prescale_r <= 4'h0;
    end else if (timebase_select == `CAWW_TB_OSC8) begin
      if (osc_sync_r[1] && !osc_sync_r[2]) begin
        prescale_r <= (prescale_r == prescale_last) ? 4'h0 : prescale_r + 4'h1;
      end
    end else begin
      prescale_r <= (prescale_r == prescale_last) ? 4'h0 : prescale_r + 4'h1;
    end
  end

  // Counter; software writes ignored while the watchdog runs
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_low_byte_r <= `CAWW_ZERO8;
      count_high_byte_r <= `CAWW_ZERO8;
    end else if (wdog_reset_r) begin
      count_low_byte_r <= `CAWW_ZERO8;
      count_high_byte_r <= `CAWW_ZERO8;
    end else if (wr && addr == `CAWW_A_CNTL && !watchdog_on) begin
      count_low_byte_r <= wbyte;
    end else if (wr && addr == `CAWW_A_CNTH && !watchdog_on) begin
      count_high_byte_r <= wbyte;
    end else if (counter_go && tick) begin
      count_low_byte_r <= count_low_byte_r + 8'h01;
      if (low_wrap) begin
        count_high_byte_r <= count_high_byte_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      counter_mode_r <= `CAWW_MD_RST;
    end else if (wdog_reset_r) begin
      counter_mode_r <= `CAWW_MD_RST;
    end else if (wr && addr == `CAWW_A_MODE) begin
      if (watchdog_on) begin
        // Timebase and idle frozen; lock sticks once set
        counter_mode_r[`CAWW_MD_WDE] <= wbyte[`CAWW_MD_WDE];
        counter_mode_r[`CAWW_MD_WLK] <= counter_mode_r[`CAWW_MD_WLK] | wbyte[`CAWW_MD_WLK];
        counter_mode_r[`CAWW_MD_OVIE] <= wbyte[`CAWW_MD_OVIE];
      end else begin
        counter_mode_r <= wbyte;
      end
    end
  end

  // Run bit stores only what software wrote, so it reads zero until set
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      counter_run_r <= 1'b0;
      count_ovf_r <= 1'b0;
    end else if (wdog_reset_r) begin
      counter_run_r <= 1'b0;
      count_ovf_r <= 1'b0;
    end else begin
      if (wr && addr == `CAWW_A_CTRL) begin
        counter_run_r <= wbyte[`CAWW_CT_RUN];
      end
      if (full_wrap) begin
        count_ovf_r <= 1'b1;
      end else if (wr && addr == `CAWW_A_CTRL) begin
        count_ovf_r <= wbyte[`CAWW_CT_OVF];
      end
    end
  end

  // Compare modules
  for (genvar m = 0; m < `CAWW_NMOD; m++) begin : g_mod
    localparam logic [11:0] BASE = 12'(`CAWW_A_MOD0 + m * `CAWW_A_STEP);
    logic wd_mod;
    logic hit_low;
    logic hit_word;
    logic wr_mode;
    logic wr_low;
    logic wr_high;
    logic next_low_hit;
    logic next_word_hit;
    caww_wave_type wave;
    assign wd_mod = (m == `CAWW_WDOG_MOD) && watchdog_on;
    assign wave = wave_of(module_mode_r[m]);
    assign hit_low = counter_go && tick && count_low_byte_r == compare_low_byte_r[m];
    assign hit_word = hit_low && count_high_byte_r == compare_high_byte_r[m];
    // PWM pins follow the count the tick lands on, so 8-bit duty is exactly 256 - high byte
    assign next_low_hit = counter_go && tick &&
      8'(count_low_byte_r + 8'h01) == compare_low_byte_r[m];
    assign next_word_hit = counter_go && tick &&
      16'({count_high_byte_r, count_low_byte_r} + 16'h0001) ==
      {compare_high_byte_r[m], compare_low_byte_r[m]};
    assign wr_mode = wr && addr == BASE;
    assign wr_low = wr && addr == BASE + 12'h004;
    assign wr_high = wr && addr == BASE + 12'h008;

    always_comb begin
      if (!module_mode_r[m][`CAWW_MM_CMP]) begin
        match_evt[m] = 1'b0;
      end else if (wave == CAWW_WF_FREQ || wave == CAWW_WF_PWM8) begin
        match_evt[m] = hit_low;
      end else if (wd_mod) begin
        match_evt[m] = 1'b0;
      end else begin
        match_evt[m] = hit_word;
      end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
        module_mode_r[m] <= 8'h00;
      end else if (wdog_reset_r) begin
        module_mode_r[m] <= 8'h00;
      end else if (wd_mod) begin
        module_mode_r[m] <= `CAWW_MM_TIMER;
      end else if (wr_mode) begin
        module_mode_r[m] <= wbyte;
      end else if (wr_low) begin
        module_mode_r[m][`CAWW_MM_CMP] <= 1'b0;
      end else if (wr_high) begin
        module_mode_r[m][`CAWW_MM_CMP] <= 1'b1;
      end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
        compare_low_byte_r[m] <= `CAWW_ZERO8;
        compare_high_byte_r[m] <= `CAWW_ZERO8;
      end else if (wdog_reset_r) begin
        compare_low_byte_r[m] <= `CAWW_ZERO8;
        compare_high_byte_r[m] <= `CAWW_ZERO8;
      end else if (wr_low) begin
        compare_low_byte_r[m] <= wbyte;
      end else if (wr_high && wd_mod) begin
        compare_high_byte_r[m] <= count_high_byte_r + compare_low_byte_r[m];
      end else if (wr_high) begin
        compare_high_byte_r[m] <= wbyte;
      end else if (wave == CAWW_WF_FREQ && match_evt[m]) begin
        // 8-bit add wraps, so a zero step is a full 256 ticks
        compare_low_byte_r[m] <= compare_low_byte_r[m] + compare_high_byte_r[m];
      end else if (wave == CAWW_WF_PWM8 && low_wrap) begin
        compare_low_byte_r[m] <= compare_high_byte_r[m];
      end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
        module_output_pin_r[m] <= 1'b0;
      end else if (wdog_reset_r) begin
        module_output_pin_r[m] <= 1'b0;
      end else if (wave == CAWW_WF_FREQ) begin
        if (match_evt[m]) begin
          module_output_pin_r[m] <= !module_output_pin_r[m];
        end
      end else if (wave == CAWW_WF_PWM8 || wave == CAWW_WF_PWM16) begin
        // On overflow a zero compare value keeps the pin high: full duty
        if (!module_mode_r[m][`CAWW_MM_CMP]) begin
          module_output_pin_r[m] <= 1'b0;
        end else if (wave == CAWW_WF_PWM8 ? low_wrap : full_wrap) begin
          module_output_pin_r[m] <= (wave == CAWW_WF_PWM8) ?
            (compare_high_byte_r[m] == `CAWW_ZERO8) :
            ({compare_high_byte_r[m], compare_low_byte_r[m]} == 16'h0000);
        end else if (wave == CAWW_WF_PWM8 ? next_low_hit : next_word_hit) begin
          module_output_pin_r[m] <= 1'b1;
        end
      end
    end
  end

  // Sticky flags: hardware set wins over a software clear
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      module_event_flag_r <= 6'h00;
    end else if (wdog_reset_r) begin
      module_event_flag_r <= 6'h00;
    end else begin
      for (int i = 0; i < `CAWW_NMOD; i++) begin
        if (match_evt[i]) begin
          module_event_flag_r[i] <= 1'b1;
        end else if (wr && addr == `CAWW_A_CTRL) begin
          module_event_flag_r[i] <= wbyte[i];
        end
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= 1'b0;
      for (int i = 0; i < `CAWW_NMOD; i++) begin
        if (module_event_flag_r[i] && module_mode_r[i][`CAWW_MM_IE]) begin
          irq_r <= 1'b1;
        end
      end
      if (count_ovf_r && counter_mode_r[`CAWW_MD_OVIE]) begin
        irq_r <= 1'b1;
      end
    end
  end

  // Watchdog reset; single cycle since the pulse clears itself on the next clock
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wdog_reset_r <= 1'b0;
    end else if (wdog_reset_r) begin
      wdog_reset_r <= 1'b0;
    end else if (watchdog_on && low_wrap &&
                 compare_high_byte_r[`CAWW_WDOG_MOD] == count_high_byte_r) begin
      wdog_reset_r <= 1'b1;
    end else if (watchdog_on && wr && addr == `CAWW_A_CTRL && wbyte[`CAWW_WDOG_MOD]) begin
      wdog_reset_r <= 1'b1;
    end
  end

  // APB slave: zero wait, unmapped reads zero with an error
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rsp_r <= '0;
    end else begin
      rsp_r.pready <= apb_in.psel && !apb_in.penable;
      rsp_r.pslverr <= apb_in.psel && !apb_in.penable && !(apb_in.paddr <= `CAWW_A_CNTH ||
                       (is_mod(apb_in.paddr) && apb_in.paddr[3:2] != 2'b11));
      rsp_r.prdata <= 32'h0000_0000;
      if (apb_in.psel && !apb_in.penable && !apb_in.pwrite) begin
        case (apb_in.paddr)
          `CAWW_A_CTRL: rsp_r.prdata[7:0] <= {count_ovf_r, counter_run_r, module_event_flag_r};
          `CAWW_A_MODE: rsp_r.prdata[7:0] <= counter_mode_r;
          `CAWW_A_CNTL: rsp_r.prdata[7:0] <= count_low_byte_r;
          `CAWW_A_CNTH: rsp_r.prdata[7:0] <= count_high_byte_r;
          default: begin
            if (is_mod(apb_in.paddr)) begin
              case (apb_in.paddr[3:2])
                2'b00: rsp_r.prdata[7:0] <= module_mode_r[3'((apb_in.paddr - `CAWW_A_MOD0) >> 4)];
                2'b01: rsp_r.prdata[7:0] <= compare_low_byte_r[3'((apb_in.paddr - `CAWW_A_MOD0) >> 4)];
                2'b10: rsp_r.prdata[7:0] <= compare_high_byte_r[3'((apb_in.paddr - `CAWW_A_MOD0) >> 4)];
                default: rsp_r.prdata[7:0] <= 8'h00;
              endcase
            end
          end
        endcase
      end
    end
  end

  assign apb_out = rsp_r;
  assign module_output_pin_out = module_output_pin_r;
  assign irq_out = irq_r;
  assign wdog_reset_out = wdog_reset_r;
endmodule
`default_nettype wire

/* File: caww_props.sv */
// Checker for caww_core: APB answer timing and the watchdog reset pulse.
// Assumes it is bound to caww_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "caww_cfg.svh"
module caww_props (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire caww_pkg::caww_apb_req_type apb_in,
  input wire caww_pkg::caww_apb_rsp_type apb_out,
  input wire logic [5:0] module_output_pin_out,
  input wire logic irq_out,
  input wire logic wdog_reset_out
);
  import caww_pkg::*;
  logic wd_on_r;
  logic lock_r;
  wire logic acc = apb_in.psel && apb_in.penable;
  wire logic wr_mode = acc && apb_in.pwrite && apb_in.paddr == `CAWW_A_MODE;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // Watchdog state as the bus implies it
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wd_on_r <= 1'b1;
      lock_r <= 1'b0;
    end else if (wdog_reset_out) begin
      wd_on_r <= 1'b1;
      lock_r <= 1'b0;
    end else if (wr_mode) begin
      wd_on_r <= apb_in.pwdata[6] | apb_in.pwdata[5] | lock_r;
      lock_r <= lock_r | apb_in.pwdata[5];
    end
  end
  sequence s_setup;
    apb_in.psel && !apb_in.penable;
  endsequence
  sequence s_force;
    acc && apb_in.pwrite && apb_in.paddr == `CAWW_A_CTRL && apb_in.pwdata[5] && wd_on_r;
  endsequence
  a_zero_wait: assert property (s_setup |=> apb_out.pready)
    else $error("pready missing in access cycle");
  a_ready_access: assert property (apb_out.pready |-> acc)
    else $error("pready outside access phase");
  a_ready_single: assert property (apb_out.pready |=> !apb_out.pready)
    else $error("pready held too long");
  a_err_ready: assert property (apb_out.pslverr |-> apb_out.pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (apb_out.pslverr && !apb_in.pwrite |-> apb_out.prdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_force_reset: assert property (s_force |-> ##[1:2] wdog_reset_out)
    else $error("forced watchdog reset missing");
  a_wdog_single: assert property (wdog_reset_out |=> !wdog_reset_out)
    else $error("watchdog reset longer than one cycle");
  a_wdog_needs_on: assert property (wdog_reset_out |-> wd_on_r)
    else $error("watchdog reset while disabled");
  a_reset_clears: assert property (wdog_reset_out |=> ##1 !irq_out && module_output_pin_out == 6'h00)
    else $error("state not cleared after watchdog reset");
endmodule
bind caww_core caww_props chk_u (
  .clock_in(clock_in),
  .nrst_in(nrst_in),
  .apb_in(apb_in),
  .apb_out(apb_out),
  .module_output_pin_out(module_output_pin_out),
  .irq_out(irq_out),
  .wdog_reset_out(wdog_reset_out)
);
`default_nettype wire

/* File: caww_cpu_model.sv */
// CPU side of the register bus: an APB master with transfer tasks.
// Assumes one clock shared with the core; the bench calls its tasks.
`timescale 1ns/1ps
`default_nettype none
`include "caww_cfg.svh"
module caww_cpu_model (
  input wire logic clock_in,
  output var caww_pkg::caww_apb_req_type apb_out,
  input wire caww_pkg::caww_apb_rsp_type apb_in
);
  import caww_pkg::*;
  initial apb_out = '0;
  // Holds the request until pready is sampled; no wait count is assumed
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic er);
    @(posedge clock_in);
    apb_out <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clock_in);
    apb_out.penable <= 1'b1;
    @(posedge clock_in);
    while (apb_in.pready !== 1'b1) begin
      @(posedge clock_in);
    end
    q = apb_in.prdata;
    er = apb_in.pslverr;
    apb_out <= '0;
  endtask
  // Low byte first, since the high byte write re-arms the compare
  task automatic load_pair(input logic [11:0] a, input logic [7:0] lo, input logic [7:0] hi);
    logic [31:0] q;
    logic er;
    xfer(1'b1, a, {24'h00_0000, lo}, q, er);
    xfer(1'b1, a + 12'h004, {24'h00_0000, hi}, q, er);
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Testbench for caww_core: waveform modes and watchdog, driven over APB.
// Assumes caww_cpu_model as bus master and caww_props bound to the core.
`timescale 1ns/1ps
`default_nettype none
`include "caww_cfg.svh"
module tb_top;
  import caww_pkg::*;
  logic clock_in;
  logic nrst_in;
  logic tick_t0_in;
  logic ext_edge_in;
  logic ext_osc_in;
  logic idle_in;
  caww_apb_req_type apb_req;
  caww_apb_rsp_type apb_rsp;
  logic [5:0] pins;
  logic irq;
  logic wdog_rst;
  logic [31:0] seed = 32'h0000_54AF;
  logic [31:0] tmp;
  logic [31:0] q;
  logic er;
  logic [7:0] hb;
  int mismatches = 0;
  int checks = 0;
  int n;
  caww_core dut_u (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .apb_in(apb_req),
    .apb_out(apb_rsp),
    .tick_t0_in(tick_t0_in),
    .ext_edge_in(ext_edge_in),
    .ext_osc_in(ext_osc_in),
    .idle_in(idle_in),
    .module_output_pin_out(pins),
    .irq_out(irq),
    .wdog_reset_out(wdog_rst)
  );
  caww_cpu_model cpu_u (
    .clock_in(clock_in),
    .apb_out(apb_req),
    .apb_in(apb_rsp)
  );
  always #20 clock_in = ~clock_in;
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Unused timebase inputs still toggle so their sync logic runs
  always @(posedge clock_in) begin
    logic [31:0] r;
    r = xs();
    tick_t0_in <= r[3];
    ext_edge_in <= r[7];
    ext_osc_in <= r[11];
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic check_count(input string nm, input int e, input int g);
    checks++;
    if (g != e) begin
      mismatches++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    cpu_u.xfer(1'b1, a, {24'h00_0000, d}, r, e);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    logic x;
    cpu_u.xfer(1'b0, a, 32'h0000_0000, r, x);
    check_reg(nm, e, r);
  endtask
  task automatic ones(input int m, output int k);
    k = 0;
    repeat (256) begin
      @(posedge clock_in);
      k += int'(pins[m] === 1'b1);
    end
  endtask
  // Length of one whole high phase; partial phases are skipped
  task automatic high_len(input int m, input int lim, output int k);
    k = 0;
    while (pins[m] === 1'b1 && k < lim) begin
      @(posedge clock_in);
      k++;
    end
    k = 0;
    while (pins[m] !== 1'b1 && k < lim) begin
      @(posedge clock_in);
      k++;
    end
    k = 0;
    while (pins[m] === 1'b1 && k < lim) begin
      @(posedge clock_in);
      k++;
    end
  endtask
  task automatic wait_rst(input int lim, output int k);
    k = 0;
    while (wdog_rst !== 1'b1 && k < lim) begin
      @(posedge clock_in);
      k++;
    end
  endtask
  initial begin
    #(40 * 20000);
    mismatches++;
    give_verdict();
  end
  initial begin
    clock_in = 1'b0;
    nrst_in = 1'b0;
    idle_in = 1'b0;
    tick_t0_in = 1'b0;
    ext_edge_in = 1'b0;
    ext_osc_in = 1'b0;
    repeat (3) @(posedge clock_in);
    nrst_in <= 1'b1;
    rd("mode_rst", 12'h004, 32'h0000_0040);
    rd("offset_rst", 12'h064, 32'h0000_0000);
    rd("ctrl_rst", 12'h000, 32'h0000_0000);
    wr(12'h060, 8'h00);
    rd("m5_mode", 12'h060, 32'h0000_0048);
    wr(12'h004, 8'h48);
    rd("tbase_frozen", 12'h004, 32'h0000_0040);
    cpu_u.xfer(1'b0, 12'h0FC, 32'h0000_0000, q, er);
    check_reg("unmapped_err", 32'h0000_0001, {31'h0000_0000, er});
    check_reg("unmapped_data", 32'h0000_0000, q);
    $display("test reset done");
    wr(12'h004, 8'h00);
    wr(12'h004, 8'h08);
    wr(12'h000, 8'h40);
    for (int i = 0; i < 2; i++) begin
      tmp = xs();
      hb = (i == 0) ? tmp[7:0] : 8'h00;
      wr(12'h010, 8'h46);
      wr(12'h014, 8'h00);
      rd("cmp_clear", 12'h010, 32'h0000_0006);
      wr(12'h018, hb);
      rd("cmp_set", 12'h010, 32'h0000_0046);
      high_len(0, 1000, n);
      check_count("half_period", (hb == 8'h00) ? 256 : int'(hb), n);
    end
    wr(12'h010, 8'h47);
    repeat (2) @(posedge clock_in);
    check_reg("irq_flag", 32'h0000_0001, {31'h0000_0000, irq});
    wr(12'h010, 8'h46);
    $display("test frequency done");
    for (int i = 0; i < 3; i++) begin
      tmp = xs();
      hb = (i == 0) ? tmp[7:0] : {8{i[0]}};
      wr(12'h020, 8'h42);
      cpu_u.load_pair(12'h024, ~hb, hb);
      repeat (300) @(posedge clock_in);
      ones(1, n);
      check_count("pwm8_high", 256 - int'(hb), n);
    end
    wr(12'h024, 8'h00);
    repeat (300) @(posedge clock_in);
    ones(1, n);
    check_count("pwm8_off", 0, n);
    $display("test pwm8 done");
    wr(12'h030, 8'hC2);
    // Loaded once, before the first match
    cpu_u.load_pair(12'h034, 8'h00, 8'hFF);
    wr(12'h00C, 8'hFE);
    high_len(2, 70000, n);
    check_count("pwm16_high", 65536 - int'(16'hFF00), n);
    $display("test pwm16 done");
    wr(12'h064, 8'h01);
    wr(12'h004, 8'h48);
    wr(12'h068, 8'h00);
    wait_rst(2000, n);
    check_count("wdog_window", 1, int'(n >= 250 && n <= 520));
    rd("mode_after", 12'h004, 32'h0000_0040);
    rd("offset_after", 12'h064, 32'h0000_0000);
    wr(12'h004, 8'h20);
    wr(12'h004, 8'h00);
    wr(12'h000, 8'h20);
    wait_rst(5, n);
    check_count("forced_rst", 1, int'(n < 5));
    $display("test watchdog done");
    give_verdict();
  end
endmodule
`default_nettype wire
